// ### logic/ris_pkg.sv
// Shared constants and types of the two-wire register access link.
package ris_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int SCL_MAX_HZ = 400_000;
    // A quarter of the fastest bus period, rounded up so the bus never runs too fast.
    localparam int QUARTER_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
    localparam int TIMEOUT_S = 1;
    localparam int TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;

    // ------------------------------------------------------------
    // Protocol values
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h51;
    localparam logic [7:0] IDLE_DATA = 8'hff;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Command queue
    // ------------------------------------------------------------
    localparam int CMD_FIFO_DEPTH = 4;
    localparam int CMD_W = 10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RIS_OP_START, RIS_OP_WRITE, RIS_OP_READ, RIS_OP_STOP} ris_op_t;
    typedef enum logic [2:0] {
        RIS_T_IDLE, RIS_T_ADDR, RIS_T_AACK, RIS_T_WBYTE, RIS_T_WACK, RIS_T_RBYTE, RIS_T_RACK
    } ris_tgt_st_t;
    typedef enum logic [1:0] {RIS_C_IDLE, RIS_C_START, RIS_C_BIT, RIS_C_STOP} ris_ctl_st_t;

endpackage

// ### logic/ris_if.sv
// Two-wire link between the bus controller and the register target.
`timescale 1ns/100ps
interface ris_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // The data wire is pulled up and low whenever an enabled driver pulls it low.
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

// ### logic/ris_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module ris_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Filling side.
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic vld;
        logic rdy;
    } ris_fifo_state_t;

    ris_fifo_state_t q;
    ris_fifo_state_t d;
    logic push;
    logic pop;

    // Handshakes only complete against registered flags, so full and empty are exact.
    assign push = in_valid & q.rdy;
    assign pop = out_ready & q.vld;
    assign in_ready = q.rdy;
    assign out_valid = q.vld;
    assign out_data = q.mem[q.rp];

    // Pointer and occupancy update; depth is expected to be a power of two.
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        d.vld = (d.cnt != '0);
        d.rdy = (d.cnt != (AW + 1)'(D));
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // ris_fifo

// ### logic/ris_target.sv
// Register target end of the two-wire link.
`timescale 1ns/100ps
// Functional notes
// [RULE1] Answer only target address 1010001b.
// [RULE2] Other addresses: no acknowledge, ignore transfer.
// [RULE3] Address MSB first; eighth bit gives direction.
// [RULE4] Works with bus clocks up to 400 kHz.
// [RULE5] SDA falling while SCL high is START.
// [RULE6] SDA rising while SCL high is STOP.
// [RULE7] Repeated START acts as STOP then START.
// [RULE8] SDA changes only while SCL is low.
// [RULE9] Transfer lasting one second clears the interface.
// [RULE10] After timeout: writes ignored, reads give FFh.
// [RULE11] Controller restarts with a new START.
// [RULE12] Eight-bit bytes, ninth pulse carries acknowledge.
// [RULE13] Receiver acknowledges each byte, low whole pulse.
// [RULE14] Controller nacks last byte; target releases SDA.
// [RULE15] Pointer advances by one per data byte.
// [RULE16] First written byte loads the pointer.
// [RULE17] Write ends at STOP or next START.
// [RULE18] Pointer write then repeated START reads there.
// [RULE19] Plain read continues after last accessed register.
// [RULE20] Bus clock is input only, never driven.
// [RULE21] Unlimited bytes per transfer within time limit.
// [RULE22] Controller starts only on an idle bus.
// [RULE23] Timeout restarts at START, stops at STOP.
module ris_target #(
    parameter logic [31:0] TIMEOUT_CYCLES = ris_pkg::TIMEOUT_CYC
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Two-wire link.
    ris_if.dev LINK,
    // Register file read port.
    output logic [7:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    // Register file write port.
    output logic WR_STROBE,
    output logic [7:0] WR_ADDR,
    output logic [7:0] WR_DATA,
    // Status.
    output logic BUSY,
    output logic TIMED_OUT
);
    import ris_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ris_tgt_st_t st;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic rw;
        logic ptr_load;
        logic oe;
        logic nack;
        logic busy;
        logic tmo;
        logic wr;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic [31:0] tmr;
    } ris_tgt_state_t;

    ris_tgt_state_t q;
    ris_tgt_state_t d;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic tmo_hit;

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    // Events use only the second and third synchroniser stages, never the first.
    assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
    assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
    assign start_c = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2]; // [RULE5]
    assign stop_c = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2]; // [RULE6]
    assign tmo_hit = q.busy && (q.tmr >= TIMEOUT_CYCLES - 32'h1); // [RULE9]

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The clock wire has no driver here; only the data wire is pulled low.
    assign LINK.dev_sda_o = 1'b0; // [RULE20]
    assign LINK.dev_sda_oe = q.oe;
    assign RD_ADDR = q.ptr;
    assign WR_STROBE = q.wr;
    assign WR_ADDR = q.wr_addr;
    assign WR_DATA = q.wr_data;
    assign BUSY = q.busy;
    assign TIMED_OUT = q.tmo;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Sampling happens on SCL rising and driving on SCL falling, so SDA
    // is steady through every high phase at any rate up to fast mode.
    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[1:0], LINK.scl};
        d.sda_s = {q.sda_s[1:0], LINK.sda};
        d.wr = 1'b0;
        if (q.busy) begin
            d.tmr = q.tmr + 32'h1;
        end
        if (start_c) begin
            // A START anywhere aborts the current transfer and begins a new one.
            d.st = RIS_T_ADDR; // [RULE7] [RULE17]
            d.cnt = 4'h0;
            d.oe = 1'b0;
            d.busy = 1'b1;
            d.tmo = 1'b0; // [RULE11]
            d.tmr = 32'h0; // [RULE23]
        end else if (stop_c) begin
            d.st = RIS_T_IDLE; // [RULE6] [RULE17]
            d.oe = 1'b0;
            d.busy = 1'b0; // [RULE23]
        end else if (tmo_hit) begin
            // Standby until the next START: the wire floats high, so reads
            // see FFh, and no write strobe can be raised from idle.
            d.st = RIS_T_IDLE; // [RULE9] [RULE10]
            d.oe = 1'b0;
            d.busy = 1'b0;
            d.tmo = 1'b1;
        end else begin
            case (q.st)
                RIS_T_ADDR: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[6:0], q.sda_s[1]}; // [RULE3] [RULE8]
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BYTE_BITS) begin
                        d.cnt = 4'h0;
                        if (q.sh[7:1] == TARGET_ADDR) begin // [RULE1]
                            d.rw = q.sh[0]; // [RULE3]
                            d.oe = 1'b1; // [RULE13]
                            d.st = RIS_T_AACK;
                        end else begin
                            d.st = RIS_T_IDLE; // [RULE2]
                        end
                    end
                end
                RIS_T_AACK: begin
                    if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.rw) begin
                            // Reads start at the current pointer.
                            d.tx = RD_DATA; // [RULE18] [RULE19]
                            d.oe = ~RD_DATA[7]; // [RULE8]
                            d.st = RIS_T_RBYTE;
                        end else begin
                            d.oe = 1'b0;
                            d.ptr_load = 1'b1; // [RULE16]
                            d.st = RIS_T_WBYTE;
                        end
                    end
                end
                RIS_T_WBYTE: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[6:0], q.sda_s[1]}; // [RULE12]
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BYTE_BITS) begin
                        d.cnt = 4'h0;
                        d.oe = 1'b1; // [RULE13]
                        d.st = RIS_T_WACK;
                        if (q.ptr_load) begin
                            d.ptr = q.sh; // [RULE16]
                            d.ptr_load = 1'b0;
                        end else begin
                            d.wr = 1'b1; // [RULE21]
                            d.wr_addr = q.ptr;
                            d.wr_data = q.sh;
                            d.ptr = q.ptr + 8'h1; // [RULE15]
                        end
                    end
                end
                RIS_T_WACK: begin
                    if (scl_fall) begin
                        d.oe = 1'b0;
                        d.st = RIS_T_WBYTE;
                    end
                end
                RIS_T_RBYTE: begin
                    if (scl_fall) begin
                        if (q.cnt == BYTE_BITS - 4'h1) begin
                            // Release for the controller's acknowledge slot.
                            d.oe = 1'b0; // [RULE12]
                            d.ptr = q.ptr + 8'h1; // [RULE15]
                            d.st = RIS_T_RACK;
                        end else begin
                            d.cnt = q.cnt + 4'h1;
                            d.tx = {q.tx[6:0], 1'b0};
                            d.oe = ~q.tx[6]; // [RULE3] [RULE8]
                        end
                    end
                end
                RIS_T_RACK: begin
                    if (scl_rise) begin
                        d.nack = q.sda_s[1];
                    end else if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (!q.nack) begin
                            d.tx = RD_DATA; // [RULE21]
                            d.oe = ~RD_DATA[7];
                            d.st = RIS_T_RBYTE;
                        end else begin
                            // Leave the wire released so the controller can STOP.
                            d.st = RIS_T_IDLE; // [RULE14]
                        end
                    end
                end
                RIS_T_IDLE: begin
                    d.oe = 1'b0;
                end
                default: begin
                    d.st = RIS_T_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Everything clears to zero; the pointer clears to PTR_RESET, also zero.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            q <= '0;
        end else begin
            q <= d; // [RULE4]
        end
    end
endmodule // ris_target

// ### logic/ris_ctrl.sv
// Bus controller end of the two-wire link, fed by a command queue.
`timescale 1ns/100ps
module ris_ctrl #(
    parameter int QUARTER = ris_pkg::QUARTER_CYC,
    parameter int DEPTH = ris_pkg::CMD_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Two-wire link.
    ris_if.host LINK,
    // Command queue input.
    input wire logic CMD_VALID,
    input wire ris_pkg::ris_op_t CMD_OP,
    input wire logic [7:0] CMD_DATA,
    output logic CMD_READY,
    // Byte results and busy status.
    output logic RSP_VALID,
    output logic [7:0] RSP_DATA,
    output logic RSP_NACK,
    output logic BUSY
);
    import ris_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ris_ctl_st_t st;
        logic [15:0] div;
        logic [1:0] ph;
        logic [3:0] n;
        logic [8:0] sh;
        logic [8:0] rx;
        logic scl_n;
        logic oe;
        logic [1:0] sda_s;
        logic rsp_v;
        logic [7:0] rsp_d;
        logic rsp_n;
        logic busy;
    } ris_ctl_state_t;

    ris_ctl_state_t q;
    ris_ctl_state_t d;
    logic tick;
    logic f_v;
    logic [CMD_W-1:0] f_d;
    logic pop;
    ris_op_t op;

    // Quarter-period enable; the engine only pulls commands while idle.
    assign tick = (q.div == 16'(QUARTER - 1));
    assign pop = (q.st == RIS_C_IDLE) & tick & f_v;
    assign op = ris_op_t'(f_d[9:8]);

    ris_fifo #(.W(CMD_W), .D(DEPTH)) u_cmd_fifo (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .in_valid(CMD_VALID),
        .in_data({CMD_OP, CMD_DATA}),
        .in_ready(CMD_READY),
        .out_valid(f_v),
        .out_data(f_d),
        .out_ready(pop)
    );

    // Link and result outputs.
    assign LINK.scl = ~q.scl_n;
    assign LINK.host_sda_o = 1'b0;
    assign LINK.host_sda_oe = q.oe;
    assign RSP_VALID = q.rsp_v;
    assign RSP_DATA = q.rsp_d;
    assign RSP_NACK = q.rsp_n;
    assign BUSY = q.busy;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Each bit is four quarters: set data, raise SCL, hold or sample, lower SCL.
    always_comb begin
        d = q;
        d.sda_s = {q.sda_s[0], LINK.sda};
        d.rsp_v = 1'b0;
        d.div = tick ? 16'h0 : q.div + 16'h1;
        d.busy = (q.st != RIS_C_IDLE) | f_v;
        if (tick) begin
            d.ph = q.ph + 2'h1;
            case (q.st)
                RIS_C_IDLE: begin
                    d.ph = 2'h0;
                    if (f_v) begin
                        d.n = 4'h0;
                        case (op)
                            RIS_OP_START: d.st = RIS_C_START;
                            RIS_OP_WRITE: begin
                                d.sh = {f_d[7:0], 1'b1}; // [RULE12]
                                d.st = RIS_C_BIT;
                            end
                            RIS_OP_READ: begin
                                // Bit 0 of the data asks for an acknowledge.
                                d.sh = {IDLE_DATA, ~f_d[0]}; // [RULE14]
                                d.st = RIS_C_BIT;
                            end
                            default: d.st = RIS_C_STOP;
                        endcase
                    end
                end
                RIS_C_START: begin
                    // Release SDA, raise SCL, then pull SDA low under high SCL.
                    case (q.ph)
                        2'h0: d.oe = 1'b0; // [RULE22]
                        2'h1: d.scl_n = 1'b0;
                        2'h2: d.oe = 1'b1; // [RULE5] [RULE11]
                        default: begin
                            d.scl_n = 1'b1;
                            d.st = RIS_C_IDLE;
                        end
                    endcase
                end
                RIS_C_BIT: begin
                    case (q.ph)
                        2'h0: d.oe = ~q.sh[8]; // [RULE8]
                        2'h1: d.scl_n = 1'b0;
                        2'h2: d.rx = {q.rx[7:0], q.sda_s[1]};
                        default: begin
                            d.scl_n = 1'b1;
                            d.sh = {q.sh[7:0], 1'b1};
                            d.n = q.n + 4'h1;
                            if (q.n == BYTE_BITS) begin
                                d.st = RIS_C_IDLE;
                                d.rsp_v = 1'b1;
                                d.rsp_d = q.rx[8:1];
                                d.rsp_n = q.rx[0];
                            end
                        end
                    endcase
                end
                RIS_C_STOP: begin
                    case (q.ph)
                        2'h0: d.oe = 1'b1;
                        2'h1: d.scl_n = 1'b0;
                        2'h2: d.oe = 1'b0; // [RULE6]
                        default: d.st = RIS_C_IDLE;
                    endcase
                end
                default: d.st = RIS_C_IDLE;
            endcase
        end
    end

    // State register; SCL is held inverted so reset leaves the bus idle high.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // ris_ctrl

// ### testbench/ris_link_sva.sv
// Wire-level checker for the two-wire register access link.
`timescale 1ns/100ps
module ris_link_sva #(
    parameter logic [31:0] TIMEOUT_CYCLES = 32'd20000
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Link wires.
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    import ris_pkg::*;
    typedef struct packed {
        logic scl;
        logic sda;
        logic busy;
        logic first;
        logic nomatch;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [31:0] tcnt;
    } ris_chk_st_t;
    ris_chk_st_t s_q;
    ris_chk_st_t s_d;
    logic start_w;
    logic stop_w;
    logic rise_w;
    // Bus events seen straight on the wires.
    assign start_w = scl && s_q.scl && s_q.sda && !sda;
    assign stop_w = scl && s_q.scl && !s_q.sda && sda;
    assign rise_w = scl && !s_q.scl;
    // Tracks the transfer, the bit position and the received address.
    always_comb begin
        s_d = s_q;
        s_d.scl = scl;
        s_d.sda = sda;
        if (s_q.busy && s_q.tcnt != 32'hffffffff) s_d.tcnt = s_q.tcnt + 32'h1;
        if (start_w) begin
            s_d.busy = 1'b1;
            s_d.first = 1'b1;
            s_d.nomatch = 1'b0;
            s_d.bits = 4'h0;
            s_d.tcnt = 32'h0;
        end else if (stop_w) begin
            s_d.busy = 1'b0;
            s_d.nomatch = 1'b0;
        end else if (rise_w && s_q.busy) begin
            if (s_q.bits == 4'h8) begin
                s_d.bits = 4'h0;
                s_d.first = 1'b0;
            end else begin
                s_d.sh = {s_q.sh[6:0], sda};
                s_d.bits = s_q.bits + 4'h1;
                if (s_q.first && s_q.bits == 4'h6 && {s_q.sh[5:0], sda} != TARGET_ADDR)
                    s_d.nomatch = 1'b1;
            end
        end
    end
    // Registers the tracking state; the idle bus is high on both wires.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.scl <= 1'b1;
            s_q.sda <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    a_dev_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
        else $error("target took SDA while SCL high");
    a_dev_fall_low: assert property ($fell(dev_sda_oe) |-> !scl)
        else $error("target let go of SDA while SCL high");
    a_ack_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("target SDA moved during SCL high");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("SCL high phase too short");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("SCL low phase too short");
    a_idle_quiet: assert property (!s_q.busy |-> !dev_sda_oe)
        else $error("target drives SDA outside a transfer");
    a_foreign_quiet: assert property (s_q.nomatch |-> !dev_sda_oe)
        else $error("target answers a foreign address");
    a_addr_ack: assert property (rise_w && s_q.busy && s_q.first && s_q.bits == 4'h8
        && !s_q.nomatch |-> !sda)
        else $error("own address not acknowledged");
    a_timeout_quiet: assert property (s_q.busy && s_q.tcnt > TIMEOUT_CYCLES + 32'd8
        |-> !dev_sda_oe)
        else $error("target still active after the time limit");
    c_start: cover property (start_w);
    c_stop: cover property (stop_w);
    c_foreign: cover property ($rose(s_q.nomatch));
    c_timeout: cover property (s_q.busy && s_q.tcnt == TIMEOUT_CYCLES + 32'd9);
endmodule // ris_link_sva

// ### testbench/tb.sv
// Self-checking bench joining the bus controller and the register target.
`timescale 1ns/100ps
module tb;
    import ris_pkg::*;
    localparam logic [31:0] TMO = 32'd20000;
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic cmd_valid = 1'b0;
    ris_op_t cmd_op = RIS_OP_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, rsp_nack, c_busy, wr_strobe, t_busy, timed_out, full_seen;
    logic [7:0] rsp_data, rd_addr, rd_data, wr_addr, wr_data;
    logic [15:0] rsp_q[$];
    logic [15:0] wr_q[$];
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    ris_if u_ris_if ();
    ris_ctrl #(.QUARTER(40), .DEPTH(4)) u_ris_ctrl (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
        .LINK(u_ris_if), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_DATA(cmd_data),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .RSP_NACK(rsp_nack), .BUSY(c_busy));
    ris_target #(.TIMEOUT_CYCLES(TMO)) u_ris_target (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
        .LINK(u_ris_if), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .WR_STROBE(wr_strobe),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUSY(t_busy), .TIMED_OUT(timed_out));
    ris_link_sva #(.TIMEOUT_CYCLES(TMO)) u_ris_link_sva (.REF_CLK(REF_CLK),
        .RESET_N(RESET_N), .scl(u_ris_if.scl), .host_sda_o(u_ris_if.host_sda_o),
        .host_sda_oe(u_ris_if.host_sda_oe), .dev_sda_o(u_ris_if.dev_sda_o),
        .dev_sda_oe(u_ris_if.dev_sda_oe), .sda(u_ris_if.sda));
    // Register file stand-in: each register holds its address scrambled by a constant.
    function automatic logic [7:0] reg_val(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction
    assign rd_data = reg_val(rd_addr);
    always #4 REF_CLK = ~REF_CLK;
    // Collects responses and register writes, and cuts a hang short.
    always @(posedge REF_CLK) begin
        if (rsp_valid === 1'b1) rsp_q.push_back({7'h00, rsp_nack, rsp_data});
        if (wr_strobe === 1'b1) wr_q.push_back({wr_addr, wr_data});
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] take(ref logic [15:0] q[$]);
        if (q.size() == 0) return 16'hdead;
        return q.pop_front();
    endfunction
    // Offers one command and holds it until the queue takes it.
    task automatic put(input ris_op_t op, input logic [7:0] d);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        while (cmd_ready !== 1'b1) begin
            full_seen = 1'b1;
            @(negedge REF_CLK);
        end
        @(negedge REF_CLK);
    endtask
    // Ends the batch and waits until the controller goes idle, then eight cycles more.
    task automatic flush();
        cmd_valid = 1'b0;
        repeat (4) @(negedge REF_CLK);
        for (int i = 0; i < 40000 && c_busy !== 1'b0; i++) @(negedge REF_CLK);
        repeat (8) @(negedge REF_CLK);
    endtask
    // Short forms of the commands; a STOP also ends the batch.
    task automatic st();
        put(RIS_OP_START, 8'h00);
    endtask
    task automatic sp();
        put(RIS_OP_STOP, 8'h00);
        flush();
    endtask
    task automatic w(input logic [7:0] b);
        put(RIS_OP_WRITE, b);
    endtask
    task automatic rd(input logic [7:0] b);
        put(RIS_OP_READ, b);
    endtask
    // Compares the next byte result.
    task automatic cr(input logic [15:0] exp);
        chk(take(rsp_q), exp);
    endtask
    task automatic t_write();
        full_seen = 1'b0;
        st();
        w(8'ha2);
        w(8'h05);
        w(8'h3c);
        w(8'hc3);
        w(8'h96);
        sp();
        cr(16'ha2);
        cr(16'h05);
        cr(16'h3c);
        cr(16'hc3);
        cr(16'h96);
        chk(take(wr_q), 16'h053c);
        chk(take(wr_q), 16'h06c3);
        chk(take(wr_q), 16'h0796);
        chk(16'(full_seen), 16'h1);
        chk(16'(rd_addr), 16'h8);
        chk(16'(t_busy), 16'h0);
    endtask
    task automatic t_read_rs();
        st();
        w(8'ha2);
        w(8'h10);
        st();
        w(8'ha3);
        rd(8'h01);
        rd(8'h01);
        rd(8'h00);
        sp();
        cr(16'ha2);
        cr(16'h10);
        cr(16'ha3);
        cr({8'h00, reg_val(8'h10)});
        cr({8'h00, reg_val(8'h11)});
        cr({8'h01, reg_val(8'h12)});
        chk(16'(wr_q.size()), 16'h0);
    endtask
    task automatic t_read_cur();
        st();
        w(8'ha3);
        rd(8'h00);
        sp();
        cr(16'ha3);
        cr({8'h01, reg_val(8'h13)});
    endtask
    task automatic t_bad_addr();
        logic [7:0] bad [3] = '{8'ha0, 8'ha6, 8'h23};
        for (int i = 0; i < 3; i++) begin
            st();
            w(bad[i]);
            w(8'h55);
            sp();
            cr({8'h01, bad[i]});
            cr(16'h0155);
        end
        chk(16'(wr_q.size()), 16'h0);
    endtask
    task automatic t_timeout();
        st();
        w(8'ha2);
        w(8'h20);
        flush();
        // The target must give up once the time limit has run out.
        repeat (TMO + 100) @(negedge REF_CLK);
        chk(16'(timed_out), 16'h1);
        chk(16'(t_busy), 16'h0);
        w(8'h77);
        rd(8'h00);
        sp();
        cr(16'ha2);
        cr(16'h20);
        cr(16'h0177);
        cr({8'h01, IDLE_DATA});
        chk(16'(wr_q.size()), 16'h0);
        st();
        w(8'ha3);
        rd(8'h00);
        sp();
        chk(16'(timed_out), 16'h0);
        cr(16'ha3);
        cr({8'h01, reg_val(8'h20)});
    endtask
    // Main sequence: reset for four cycles, then every scenario in turn.
    initial begin
        repeat (4) @(negedge REF_CLK);
        RESET_N = 1'b1;
        repeat (3) @(negedge REF_CLK);
        t_write();
        t_read_rs();
        t_read_cur();
        t_bad_addr();
        t_timeout();
        summarize();
    end
endmodule // tb
